/* src/crf_pkg.sv */
// package of record framing constants for the capture record framer
package crf_pkg;
  // record type byte layout
  localparam int unsigned EXT_FLAG_BIT       = 7;
  localparam logic [6:0]  KIND_LEGACY        = 7'h00;
  localparam logic [6:0]  KIND_HDLC_POS      = 7'h01;
  localparam logic [6:0]  KIND_ETHERNET      = 7'h02;
  localparam logic [6:0]  KIND_ATM           = 7'h03;
  localparam logic [6:0]  KIND_AAL5          = 7'h04;
  localparam logic [6:0]  KIND_MC_FIRST      = 7'h05;
  localparam logic [6:0]  KIND_MC_LAST       = 7'h09;
  localparam logic [6:0]  KIND_COLOUR_HDLC   = 7'h0a;
  localparam logic [6:0]  KIND_COLOUR_ETH    = 7'h0b;
  localparam logic [6:0]  KIND_MC_AAL2       = 7'h0c;
  localparam logic [6:0]  KIND_DM_COLOUR_HDLC = 7'h0f;
  localparam logic [6:0]  KIND_DM_COLOUR_ETH = 7'h10;
  localparam logic [6:0]  KIND_COLOUR_MC_HDLC = 7'h11;
  localparam logic [6:0]  KIND_AAL2          = 7'h12;
  localparam logic [6:0]  KIND_HASH_POS      = 7'h13;
  localparam logic [6:0]  KIND_HASH_ETH      = 7'h14;
  localparam logic [6:0]  KIND_VAR_FIRST     = 7'h15;
  localparam logic [6:0]  KIND_VAR_LAST      = 7'h17;
  localparam logic [6:0]  KIND_RAW_LINK      = 7'h18;
  localparam logic [6:0]  KIND_RAW_FABRIC    = 7'h19;
  localparam logic [6:0]  KIND_RSVD_FIRST    = 7'h20;
  localparam logic [6:0]  KIND_RSVD_LAST     = 7'h2f;
  localparam logic [6:0]  KIND_PAD           = 7'h30;
  // sizes in bytes, chain limit, chained header kind and fill byte values
  localparam logic [15:0] FIXED_HDR_BYTES    = 16'h0010;
  localparam logic [15:0] CHAIN_HDR_BYTES    = 16'h0008;
  localparam logic [15:0] OFFSET_PAD_BYTES   = 16'h0002;
  localparam int unsigned MAX_CHAIN          = 4;
  localparam logic [6:0]  CHAN_HDR_KIND      = 7'h0c;
  localparam logic [7:0]  OFFSET_VALUE       = 8'h00;
  localparam logic [7:0]  PAD_VALUE          = 8'h00;
  // fixed header byte positions
  localparam int unsigned POS_TYPE           = 8;
  localparam int unsigned POS_FLAGS          = 9;
  localparam int unsigned POS_RLEN_HI        = 10;
  localparam int unsigned POS_RLEN_LO        = 11;
  localparam int unsigned POS_LOSS_HI        = 12;
  localparam int unsigned POS_LOSS_LO        = 13;
  localparam int unsigned POS_WLEN_HI        = 14;
  localparam int unsigned POS_WLEN_LO        = 15;
  // register offsets (bytes)
  localparam logic [7:0]  REG_CTRL           = 8'h00;
  localparam logic [7:0]  REG_COLOUR         = 8'h04;
  localparam logic [7:0]  REG_CHAN_LO        = 8'h08;
  localparam logic [7:0]  REG_CHAN_HI        = 8'h0c;
  localparam logic [7:0]  REG_STATUS         = 8'h10;
  localparam logic [7:0]  REG_LOSS           = 8'h14;
  localparam logic [7:0]  REG_RECORDS        = 8'h18;
  // control field positions
  localparam int unsigned CTRL_KIND_LSB      = 0;
  localparam int unsigned CTRL_CHAN_BIT      = 8;
  localparam logic [31:0] CTRL_RESET         = 32'h0000_0002;
endpackage

/* src/crf_kind_check.sv */
// record kind classification: legality and loss field usage
`timescale 1ns/10ps
module crf_kind_check (
  // requested kind
  input  wire logic [6:0] kind,
  // classification
  output logic            legal,
  output logic            coloured
);
  // reserved and undefined codes never leave the block; 13 and 14 are
  // counter records this framer cannot build, so they are refused too
  assign legal = (kind <= crf_pkg::KIND_MC_AAL2)
               || (kind >= crf_pkg::KIND_DM_COLOUR_HDLC
                   && kind <= crf_pkg::KIND_RAW_FABRIC)
               || (kind == crf_pkg::KIND_PAD);
  // colour kinds reuse the loss field for a colour value
  assign coloured = (kind == crf_pkg::KIND_COLOUR_HDLC)
                  || (kind == crf_pkg::KIND_COLOUR_ETH)
                  || (kind == crf_pkg::KIND_COLOUR_MC_HDLC)
                  || (kind == crf_pkg::KIND_DM_COLOUR_HDLC)
                  || (kind == crf_pkg::KIND_DM_COLOUR_ETH)
                  || (kind == crf_pkg::KIND_HASH_POS)
                  || (kind == crf_pkg::KIND_HASH_ETH);
endmodule

/* src/crf_chain_hdr.sv */
// one chained header byte generator
`timescale 1ns/10ps
module crf_chain_hdr (
  // header selection
  input  wire logic [6:0]  hdr_kind,
  input  wire logic        more,
  input  wire logic [55:0] body,
  input  wire logic [2:0]  idx,
  // byte out
  output logic [7:0]       hdr_byte
);
  // byte 0 carries the more flag and kind, bytes 1..7 the body
  assign hdr_byte = (idx == 3'h0) ? {more, hdr_kind}
                  : body[8*(7-idx) +: 8];
endmodule

/* src/crf_framer.sv */
// capture record framer: wraps received ethernet frames into records
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/10ps
module crf_framer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // frame descriptor from receive path
  input  wire logic        frm_valid,
  output logic             frm_ready,
  input  wire logic [63:0] frm_time,
  input  wire logic [15:0] frm_len,
  input  wire logic [15:0] frm_wire_len,
  input  wire logic [7:0]  frm_flags,
  // frame data bytes
  input  wire logic        dat_valid,
  input  wire logic [7:0]  dat_byte,
  output logic             dat_ready,
  // record byte stream to host buffer
  output logic             out_valid,
  output logic [7:0]       out_byte,
  output logic             out_last,
  input  wire logic        out_ready,
  // receive path drop notice
  input  wire logic        drop_pulse
);
  typedef enum logic [4:0] {
    CRF_IDLE  = 5'b00001,
    CRF_FIXED = 5'b00010,
    CRF_CHAIN = 5'b00100,
    CRF_OFFP  = 5'b01000,
    CRF_BODY  = 5'b10000
  } crf_state_t;

  crf_state_t  state;
  crf_state_t  next_state;
  logic [31:0] ctrl;
  logic [15:0] colour;
  logic [55:0] chan_body;
  logic [15:0] loss;
  logic [15:0] loss_snap;
  logic [31:0] records;
  logic [15:0] cnt;
  logic [63:0] t_time;
  logic [15:0] t_len;
  logic [15:0] t_wlen;
  logic [7:0]  t_flags;
  logic [6:0]  t_kind;
  logic        t_chain;
  logic        t_colour;
  logic        bad_kind;

  ////////////////////////////////////////////////////////////////////////
  // kind decode and chained header byte
  wire logic [6:0] req_kind  = ctrl[crf_pkg::CTRL_KIND_LSB +: 7];
  wire logic       req_chain = ctrl[crf_pkg::CTRL_CHAN_BIT];
  wire logic       kind_ok;
  wire logic       kind_col;
  wire logic [7:0] chain_byte;

  crf_kind_check u_kind (
    .kind     (req_kind),
    .legal    (kind_ok),
    .coloured (kind_col)
  );

  crf_chain_hdr u_chain (
    .hdr_kind (crf_pkg::CHAN_HDR_KIND),
    .more     (1'b0),                   // single header, last in chain
    .body     (chan_body),
    .idx      (cnt[2:0]),
    .hdr_byte (chain_byte)
  );

  // record length: fixed header, chain, offset and pad, then frame
  wire logic [15:0] chain_bytes = t_chain ? crf_pkg::CHAIN_HDR_BYTES
                                          : 16'h0000;
  wire logic [15:0] rec_len = crf_pkg::FIXED_HDR_BYTES + chain_bytes
                            + crf_pkg::OFFSET_PAD_BYTES + t_len;
  wire logic [15:0] loss_field = t_colour ? colour : loss_snap;
  wire logic [7:0]  type_byte  = {t_chain, t_kind};

  ////////////////////////////////////////////////////////////////////////
  // fixed header byte selection, timestamp little endian first
  function automatic logic [7:0] fixed_byte(input logic [3:0] i,
                                            input logic [63:0] ts,
                                            input logic [7:0] ty,
                                            input logic [7:0] fl,
                                            input logic [15:0] rl,
                                            input logic [15:0] lc,
                                            input logic [15:0] wl);
    logic [7:0] b;
    b = 8'h00;
    if (i < 4'(crf_pkg::POS_TYPE)) begin
      b = ts[8*i +: 8];
    end else begin
      unique case (i)
        4'(crf_pkg::POS_TYPE):    b = ty;
        4'(crf_pkg::POS_FLAGS):   b = fl;
        4'(crf_pkg::POS_RLEN_HI): b = rl[15:8];
        4'(crf_pkg::POS_RLEN_LO): b = rl[7:0];
        4'(crf_pkg::POS_LOSS_HI): b = lc[15:8];
        4'(crf_pkg::POS_LOSS_LO): b = lc[7:0];
        4'(crf_pkg::POS_WLEN_HI): b = wl[15:8];
        default:                  b = wl[7:0];
      endcase
    end
    return b;
  endfunction

  wire logic [7:0] hdr_byte = fixed_byte(cnt[3:0], t_time, type_byte,
                                         t_flags, rec_len, loss_field,
                                         t_wlen);
  wire logic       offp_is_pad = (cnt[0] == 1'b1);

  ////////////////////////////////////////////////////////////////////////
  // next byte and flow
  logic [7:0] next_byte;
  logic       next_valid;
  logic       next_last;
  wire logic  out_free = !out_valid || out_ready;
  // a frame byte moves only on a true handshake; ready is raised only
  // with the output empty, which halves the frame rate but keeps it honest
  wire logic  body_go  = (state == CRF_BODY) && dat_valid && dat_ready;
  wire logic  step     = (state != CRF_IDLE && state != CRF_BODY)
                         && out_free;
  wire logic  start    = (state == CRF_IDLE) && frm_valid && kind_ok;

  always_comb begin
    next_state = state;
    next_byte  = out_byte;
    next_valid = out_valid && !out_ready;
    next_last  = out_last && !out_ready;
    unique case (state)
      CRF_IDLE: begin
        if (start) next_state = CRF_FIXED;
      end
      CRF_FIXED: begin
        if (step) begin
          next_byte  = hdr_byte;
          next_valid = 1'b1;
          next_last  = 1'b0;
          if (cnt == crf_pkg::FIXED_HDR_BYTES - 16'h0001) begin
            next_state = t_chain ? CRF_CHAIN : CRF_OFFP;
          end
        end
      end
      CRF_CHAIN: begin
        if (step) begin
          next_byte  = chain_byte;
          next_valid = 1'b1;
          next_last  = 1'b0;
          if (cnt == crf_pkg::CHAIN_HDR_BYTES - 16'h0001) begin
            next_state = CRF_OFFP;
          end
        end
      end
      CRF_OFFP: begin
        if (step) begin
          // offset is unused, sent as zero
          next_byte  = offp_is_pad ? crf_pkg::PAD_VALUE
                                   : crf_pkg::OFFSET_VALUE;
          next_valid = 1'b1;
          next_last  = offp_is_pad && (t_len == 16'h0000);
          if (offp_is_pad) begin
            next_state = (t_len == 16'h0000) ? CRF_IDLE : CRF_BODY;
          end
        end
      end
      CRF_BODY: begin
        if (body_go) begin
          next_byte  = dat_byte; // frame right after pad
          next_valid = 1'b1;
          next_last  = (cnt == t_len - 16'h0001);
          if (cnt == t_len - 16'h0001) next_state = CRF_IDLE;
        end
      end
      default: next_state = CRF_IDLE;
    endcase
  end

  wire logic phase_end = (next_state != state);

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state     <= CRF_IDLE;
      cnt       <= 16'h0000;
      out_valid <= 1'b0;
      out_byte  <= 8'h00;
      out_last  <= 1'b0;
    end else begin
      state     <= next_state;
      out_valid <= next_valid;
      out_byte  <= next_byte;
      out_last  <= next_last;
      if (phase_end) cnt <= 16'h0000;
      else if (step || body_go) cnt <= cnt + 16'h0001;
    end
  end

  // descriptor capture at record start
  always_ff @(posedge clk) begin
    if (!resetn) begin
      t_time   <= 64'h0;
      t_len    <= 16'h0000;
      t_wlen   <= 16'h0000;
      t_flags  <= 8'h00;
      t_kind   <= crf_pkg::KIND_ETHERNET;
      t_chain  <= 1'b0;
      t_colour <= 1'b0;
    end else if (start) begin
      t_time   <= frm_time;
      t_len    <= frm_len;
      t_wlen   <= frm_wire_len;
      t_flags  <= frm_flags;
      t_kind   <= req_kind;
      t_chain  <= req_chain;
      t_colour <= kind_col;
    end
  end

  // loss counter: snapshot then restart per record, drop still counted
  always_ff @(posedge clk) begin
    if (!resetn) begin
      loss      <= 16'h0000;
      loss_snap <= 16'h0000;
      records   <= 32'h0;
    end else if (start) begin
      loss_snap <= loss;
      loss      <= {15'h0, drop_pulse};
      records   <= records + 32'h1;
    end else if (drop_pulse && loss != 16'hffff) begin
      loss      <= loss + 16'h0001; // saturates rather than wrap
    end
  end

  // illegal kind requests are refused and flagged
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bad_kind <= 1'b0;
    end else if (reg_wr && reg_addr == crf_pkg::REG_CTRL) begin
      bad_kind <= (state == CRF_IDLE) && frm_valid && !kind_ok;
    end else if ((state == CRF_IDLE) && frm_valid && !kind_ok) begin
      bad_kind <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl      <= crf_pkg::CTRL_RESET;
      colour    <= 16'h0000;
      chan_body <= 56'h0;
    end else if (reg_wr) begin
      if (reg_addr == crf_pkg::REG_CTRL) ctrl <= reg_wdata;
      if (reg_addr == crf_pkg::REG_COLOUR) colour <= reg_wdata[15:0];
      if (reg_addr == crf_pkg::REG_CHAN_LO) chan_body[31:0] <= reg_wdata;
      if (reg_addr == crf_pkg::REG_CHAN_HI) begin
        chan_body[55:32] <= reg_wdata[23:0];
      end
    end
  end

  wire logic [31:0] rd_mux =
    (reg_addr == crf_pkg::REG_CTRL)    ? ctrl :
    (reg_addr == crf_pkg::REG_COLOUR)  ? {16'h0, colour} :
    (reg_addr == crf_pkg::REG_CHAN_LO) ? chan_body[31:0] :
    (reg_addr == crf_pkg::REG_CHAN_HI) ? {8'h0, chan_body[55:32]} :
    (reg_addr == crf_pkg::REG_STATUS)  ? {26'h0, bad_kind, state} :
    (reg_addr == crf_pkg::REG_LOSS)    ? {16'h0, loss} :
    (reg_addr == crf_pkg::REG_RECORDS) ? records : 32'h0;

  // read data stands for one cycle only
  always_ff @(posedge clk) begin
    if (!resetn) reg_rdata <= 32'h0;
    else reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end

  // handshakes registered for the outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      frm_ready <= 1'b0;
      dat_ready <= 1'b0;
    end else begin
      frm_ready <= (next_state == CRF_IDLE);
      dat_ready <= (next_state == CRF_BODY) && !next_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_fixed_done;
    state == CRF_FIXED && step
      && cnt == crf_pkg::FIXED_HDR_BYTES - 16'h0001;
  endsequence

  a_type_byte_kind: assert property (@(posedge clk) disable iff (!resetn)
    (state == CRF_FIXED && step && cnt == 16'(crf_pkg::POS_TYPE))
    |=> out_byte[6:0] == t_kind && out_byte[7] == t_chain)
    else $error("type byte mismatch");
  a_no_reserved: assert property (@(posedge clk) disable iff (!resetn)
    start |-> !(req_kind >= crf_pkg::KIND_RSVD_FIRST
                && req_kind <= crf_pkg::KIND_RSVD_LAST))
    else $error("reserved kind started");
  a_chain_order: assert property (@(posedge clk) disable iff (!resetn)
    s_fixed_done |=> (t_chain ? state == CRF_CHAIN
                              : state == CRF_OFFP))
    else $error("chain placement wrong");
  a_chain_length: assert property (@(posedge clk) disable iff (!resetn)
    $rose(state == CRF_CHAIN) |-> (state == CRF_CHAIN)[*8])
    else $error("chain header not eight bytes");
  a_pad_zero: assert property (@(posedge clk) disable iff (!resetn)
    (state == CRF_OFFP && step) |=> out_byte == 8'h00)
    else $error("offset or pad nonzero");
  a_rec_len: assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |-> rec_len - t_len == (t_chain ? 16'h001a : 16'h0012))
    else $error("record length arithmetic");
  a_loss_colour: assert property (@(posedge clk) disable iff (!resetn)
    t_colour |-> loss_field == colour)
    else $error("colour not in loss field");
  a_loss_count: assert property (@(posedge clk) disable iff (!resetn)
    (!start && drop_pulse && $past(loss) != 16'hffff && loss != 16'hffff)
    |=> loss == $past(loss) + 16'h0001)
    else $error("drop not counted");
endmodule

/* test/crf_host_sink.sv */
// host stream buffer model: takes record bytes, prompt or stalling
`timescale 1ns/10ps
module crf_host_sink (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // record byte stream
  input  wire logic       out_valid,
  input  wire logic [7:0] out_byte,
  input  wire logic       out_last,
  output logic            out_ready,
  // pacing and progress
  input  wire logic       slow,
  output logic [15:0]     n_rec
);
  logic [7:0] got [$];

  //////////////////////////////////////////////////////////////////////////
  // store every byte; the offset byte is kept but never interpreted
  always @(posedge clk) begin
    if (!resetn) begin
      out_ready <= 1'b0;
      n_rec     <= 16'h0000;
    end else begin
      if (out_valid && out_ready) begin
        got.push_back(out_byte);
        if (out_last) n_rec <= n_rec + 16'h0001;
      end
      // a slow host stalls about three cycles in four
      out_ready <= slow ? ($urandom_range(3) == 0) : 1'b1;
    end
  end
endmodule

/* test/crf_framer_test.sv */
// self-checking testbench for the capture record framer
`timescale 1ns/10ps
module crf_framer_test;
  logic        clk;
  logic        resetn;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        frm_valid;
  logic        frm_ready;
  logic [63:0] frm_time;
  logic [15:0] frm_len;
  logic [15:0] frm_wire_len;
  logic [7:0]  frm_flags;
  logic        dat_valid;
  logic [7:0]  dat_byte;
  logic        dat_ready;
  logic        out_valid;
  logic [7:0]  out_byte;
  logic        out_last;
  logic        out_ready;
  logic        drop_pulse;
  logic        slow;
  logic [15:0] n_rec;
  logic [15:0] colour;
  logic [55:0] chan;
  logic [7:0]  src_q [$];
  int          src_idx;
  int          src_len;
  logic        src_run;
  int          n_fail;
  int          compares;
  logic [6:0]  legal_k [25] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05,
    7'h06, 7'h07, 7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h0f, 7'h10, 7'h11,
    7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h18, 7'h19, 7'h30};
  logic [6:0]  bad_k [8] = '{7'h0d, 7'h0e, 7'h1a, 7'h1f, 7'h20, 7'h2f,
    7'h31, 7'h7f};

  always #5 clk = ~clk;

  crf_framer i_crf_framer (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .frm_valid(frm_valid), .frm_ready(frm_ready),
    .frm_time(frm_time), .frm_len(frm_len), .frm_wire_len(frm_wire_len),
    .frm_flags(frm_flags), .dat_valid(dat_valid), .dat_byte(dat_byte),
    .dat_ready(dat_ready), .out_valid(out_valid), .out_byte(out_byte),
    .out_last(out_last), .out_ready(out_ready), .drop_pulse(drop_pulse));

  crf_host_sink i_crf_host_sink (.clk(clk), .resetn(resetn),
    .out_valid(out_valid), .out_byte(out_byte), .out_last(out_last),
    .out_ready(out_ready), .slow(slow), .n_rec(n_rec));

  //////////////////////////////////////////////////////////////////////////
  // frame byte source: starts only once a descriptor is taken, so no
  // stale byte can slip in ahead of the record
  always @(posedge clk) begin
    if (frm_valid && frm_ready) begin
      src_idx = 0;
      src_run = 1'b1;
    end else if (dat_valid && dat_ready) src_idx++;
    if (src_idx >= src_len) src_run = 1'b0;
    if (!dat_valid || dat_ready) begin
      dat_valid <= src_run && ($urandom_range(3) != 0);
      dat_byte  <= src_run ? src_q[src_idx] : 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // comparisons and verdict
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // expectations
  function automatic logic [15:0] exp_rlen(input logic ch, input int len);
    return crf_pkg::FIXED_HDR_BYTES + (ch ? crf_pkg::CHAIN_HDR_BYTES : 16'h0)
      + crf_pkg::OFFSET_PAD_BYTES + 16'(len);
  endfunction

  function automatic logic [15:0] exp_loss(input logic [6:0] k, input int d);
    if (k inside {7'h0a, 7'h0b, 7'h0f, 7'h10, 7'h11, 7'h13, 7'h14})
      return colour;
    return 16'(d);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // register port cycles
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // one record: drops while idle, descriptor, frame bytes, every byte but the offset checked
  task automatic run_rec(input logic [6:0] k, input logic ch, input int len,
                         input int drops);
    logic [63:0] t;
    logic [15:0] wl;
    logic [7:0]  fl;
    logic [7:0]  g [$];
    logic [15:0] n0;
    logic [31:0] lr;
    int          o;
    int          w;
    t  = {$urandom, $urandom};
    wl = 16'(len) + 16'h0004;
    fl = 8'($urandom);
    reg_write(crf_pkg::REG_CTRL, {23'h0, ch, 1'b0, k});
    for (int i = 0; i < drops; i++) begin
      @(posedge clk);
      drop_pulse <= 1'b1;
      @(posedge clk);
      drop_pulse <= 1'b0;
    end
    reg_read(crf_pkg::REG_LOSS, lr);
    cmp_word(lr, 32'(drops));
    @(posedge clk);
    src_q.delete();
    for (int i = 0; i < len; i++) src_q.push_back(8'($urandom));
    src_len = len;
    i_crf_host_sink.got.delete();
    n0 = n_rec;
    slow         <= 1'($urandom);
    frm_time     <= t;
    frm_len      <= 16'(len);
    frm_wire_len <= wl;
    frm_flags    <= fl;
    frm_valid    <= 1'b1;
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (frm_ready !== 1'b1 && w < 100);
    if (frm_ready !== 1'b1) n_fail++;
    frm_valid <= 1'b0;
    w = 0;
    while (n_rec === n0 && w < 3000) begin
      @(posedge clk);
      w++;
    end
    if (n_rec === n0) n_fail++;
    g = i_crf_host_sink.got;
    for (int i = 0; i < 8; i++) cmp_byte(g[i], t[8*i +: 8]);
    cmp_byte(g[8], {ch, k});
    cmp_byte(g[9], fl);
    cmp_word({g[10], g[11]}, exp_rlen(ch, len));
    cmp_word({g[12], g[13]}, exp_loss(k, drops));
    cmp_word({g[14], g[15]}, wl);
    if (ch) begin
      cmp_byte(g[16], {1'b0, crf_pkg::CHAN_HDR_KIND});
      for (int j = 1; j < 8; j++)
        cmp_byte(g[16 + j], chan[8*(7-j) +: 8]);
    end
    o = ch ? 24 : 16;
    cmp_byte(g[o + 1], crf_pkg::PAD_VALUE);
    for (int j = 0; j < len; j++) cmp_byte(g[o + 2 + j], src_q[j]);
    cmp_word(g.size(), exp_rlen(ch, len));
  endtask

  // illegal kind: nothing leaves, error flag set, ctrl write clears it
  task automatic refuse(input logic [6:0] k);
    logic [31:0] st;
    logic [15:0] n0;
    src_len = 0;
    reg_write(crf_pkg::REG_CTRL, {25'h0, k});
    n0 = n_rec;
    i_crf_host_sink.got.delete();
    frm_valid <= 1'b1;
    repeat (8) @(posedge clk);
    cmp_word(n_rec, n0);
    cmp_word(i_crf_host_sink.got.size(), 0);
    reg_read(crf_pkg::REG_STATUS, st);
    cmp_byte({7'h0, st[5]}, 8'h01);
    @(posedge clk);
    frm_valid <= 1'b0;
    reg_write(crf_pkg::REG_CTRL, {25'h0, crf_pkg::KIND_ETHERNET});
    reg_read(crf_pkg::REG_STATUS, st);
    cmp_byte({7'h0, st[5]}, 8'h00);
  endtask

  // watchdog sized well above the expected run of about 4000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] rd;
    clk = 1'b0;
    resetn = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {frm_valid, frm_time, frm_len, frm_wire_len, frm_flags} = '0;
    {dat_valid, dat_byte, drop_pulse, slow} = '0;
    {src_idx, src_len, src_run, n_fail, compares} = '0;
    colour = 16'h0000;
    void'($urandom(32'h923214d5));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    reg_read(crf_pkg::REG_CTRL, rd);
    cmp_word(rd, crf_pkg::CTRL_RESET);
    cmp_byte({7'h0, frm_ready}, 8'h01);
    cmp_byte({7'h0, dat_ready}, 8'h00);
    reg_read(8'h40, rd);
    cmp_word(rd, 32'h0);
    $display("test reset done");
    colour = 16'($urandom);
    reg_write(crf_pkg::REG_COLOUR, {16'h0, colour});
    chan = {24'($urandom), 32'($urandom)};
    reg_write(crf_pkg::REG_CHAN_LO, chan[31:0]);
    reg_write(crf_pkg::REG_CHAN_HI, {8'h0, chan[55:32]});
    // every legal kind; the first two carry empty and one-byte frames
    foreach (legal_k[k]) run_rec(legal_k[k], 1'($urandom),
      (k < 2) ? k : $urandom_range(24, 2), $urandom_range(3));
    $display("test kinds done");
    reg_read(crf_pkg::REG_RECORDS, rd);
    cmp_word(rd, 32'd25);
    run_rec(crf_pkg::KIND_ETHERNET, 1'b1, 40, 6);
    run_rec(crf_pkg::KIND_COLOUR_ETH, 1'b1, 3, 0);
    $display("test chained done");
    foreach (bad_k[k]) refuse(bad_k[k]);
    $display("test refusal done");
    tally_and_finish();
  end
endmodule
